//--- adb_pkg.sv
// Constants and types shared by the area decode and static bus block.
package adb_pkg;
    // =========================================================
    // Address decode
    localparam int ADDR_W = 32;
    localparam int AREA_HI = 28;
    localparam int AREA_LO = 26;
    localparam logic [2:0] AREA0_CODE = 3'h0;
    localparam logic [2:0] AREA1_CODE = 3'h1;
    localparam logic [2:0] AREA2_CODE = 3'h2;
    localparam logic [2:0] AREA3_CODE = 3'h3;
    localparam logic [2:0] AREA4_CODE = 3'h4;
    localparam logic [2:0] AREA5_CODE = 3'h5;
    localparam logic [2:0] AREA6_CODE = 3'h6;
    // Card window bit: inside the 32-Mbyte card window address bit 25 is low.
    localparam int CARD_WIN_BIT = 25;
    // =========================================================
    // Width codes
    localparam logic [1:0] WIDTH_BYTE = 2'h1;
    localparam logic [1:0] WIDTH_WORD = 2'h2;
    localparam logic [1:0] WIDTH_LONG = 2'h3;
    // =========================================================
    // Memory type codes for areas 2 and 3
    localparam logic [1:0] MEM_ORDINARY = 2'h0;
    localparam logic [1:0] MEM_DRAM = 2'h1;
    localparam logic [1:0] MEM_SDRAM = 2'h2;
    // =========================================================
    // Timing
    localparam logic [3:0] WAIT_MAX_LONG = 4'ha;
    localparam logic [3:0] WAIT_MAX_SHORT = 4'h3;
    localparam logic [3:0] BURST_PITCH_MIN = 4'h2;
    localparam logic [2:0] LINE_BEATS_M1 = 3'h3;
    localparam logic [3:0] LINE_BYTES = 4'hf;
    typedef enum {ST_IDLE, ST_FIRST, ST_WAIT, ST_FINAL} adb_state_type;
endpackage : adb_pkg

//--- adb_area_bus.sv
// Area decoder and basic two-cycle static-memory bus engine.
`timescale 1ns/1ps
// Operation
// RULE1: Address bits 28..26 codes 000..110 select areas 0..6.
// RULE2: Address bits 31..29 are ignored; upper copies alias as shadows.
// RULE3: Area 1 holds internal peripheral registers; no external memory, not cached.
// RULE4: Ordinary access drives chip select, read strobe and byte write strobes.
// RULE5: Areas 0,4,5,6 use three-bit wait field giving 0..10 waits.
// RULE6: Areas 2,3 ordinary memory use two-bit wait field giving 0..3 waits.
// RULE7: Burst pitch in areas 0,5,6 ranges 2..10 clocks from wait setting. Code: only later beats are capped; a first beat with ten waits gives pitch 12.
// RULE8: Area 0 width comes from external mode pins.
// RULE9: Areas 2..6 width from field; area 2 DRAM fixed at 16 bits.
// RULE10: Area 3 DRAM width from dram width select; SDRAM must be longword.
// RULE11: DRAM/SDRAM drive row strobe, column strobe, read/write; SDRAM byte masks.
// RULE12: Card mode areas 5,6 decode 32 Mbytes, byte or word, card strobes. Code: card strobe in area 6 only, no 32-Mbyte decode.
// RULE13: Card setup and hold programmable 0.5..3.5 cycles per area.
// RULE14: Zero-wait basic access completes in exactly two clocks.
// RULE15: Bus cycle start asserts one clock at start of each cycle.
// RULE16: Chip select drops at final-state falling edge, half-cycle gap. Code: released on the rising edge that ends the final state.
// RULE17: Reads carry no size; full device width is read.
// RULE18: Writes assert only strobes of bytes written.
// RULE19: Line fill or write-back moves 16 bytes without releasing the bus.
// RULE20: Cache fills use longword; other accesses use actual size.
// RULE21: Nonzero wait field inserts that many waits between first and final.
// RULE22: Wait pin sampled only with software waits, at last wait to final.
// RULE23: Endian strap latched at reset: low big, high little endian.
// RULE24: Area 1 accesses finish internally with no external strobes. Code still pulses the bus cycle start.
module adb_area_bus
    import adb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Straps and configuration
    input wire logic endian_strap_pin_i,
    input wire logic [1:0] area0_width_pins_i,
    input wire logic [2:0] area0_wait_field_i,
    input wire logic [1:0] area2_wait_field_i,
    input wire logic [1:0] area3_wait_field_i,
    input wire logic [2:0] area4_wait_field_i,
    input wire logic [2:0] area5_wait_field_i,
    input wire logic [2:0] area6_wait_field_i,
    input wire logic [1:0] area2_width_field_i,
    input wire logic [1:0] area3_width_field_i,
    input wire logic [1:0] area4_width_field_i,
    input wire logic [1:0] area5_width_field_i,
    input wire logic [1:0] area6_width_field_i,
    input wire logic [1:0] area2_mem_type_i,
    input wire logic [1:0] area3_mem_type_i,
    input wire logic dram_width_select_i,
    input wire logic area5_card_mode_i,
    input wire logic area6_card_mode_i,
    input wire logic [1:0] area5_card_setup_i,
    input wire logic [1:0] area5_card_hold_i,
    input wire logic [1:0] area6_card_setup_i,
    input wire logic [1:0] area6_card_hold_i,
    // Request from the core
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_size_i,
    input wire logic req_fill_i,
    input wire logic [3:0] req_bytes_i,
    output logic ack_o,
    output logic busy_o,
    // External bus
    input wire logic ext_wait_n_i,
    output logic bus_cycle_start_n_o,
    output logic [6:0] area_chip_select_n_o,
    output logic read_strobe_n_o,
    output logic [3:0] byte_write_strobes_n_o,
    output logic row_strobe_n_o,
    output logic column_strobe_n_o,
    output logic rd_wr_o,
    output logic [3:0] byte_mask_o,
    output logic card_io_n_o,
    output logic [ADDR_W-1:0] ext_addr_o,
    output logic [1:0] cycle_width_o,
    output logic [3:0] card_setup_o,
    output logic [3:0] card_hold_o,
    output logic area1_internal_o,
    output logic little_endian_o
);
    // =========================================================
    // State
    typedef struct packed {
        adb_state_type st;
        logic [3:0] waits_left;
        logic [3:0] wait_cfg;
        logic [2:0] area;
        logic [2:0] beat;
        logic fill;
        logic write;
        logic [3:0] bytes;
        logic [ADDR_W-1:0] addr;
        logic [1:0] width;
        logic busy;
        logic in1;
        logic strap_seen;
        logic little_endian;
        logic bs_n;
        logic [6:0] cs_n;
        logic rd_n;
        logic [3:0] we_n;
        logic ras_n;
        logic cas_n;
        logic rdwr;
        logic [3:0] dqm;
        logic io_n;
        logic ack;
        logic [3:0] setup;
        logic [3:0] hold;
    } adb_regs_type;

    adb_regs_type r_q;
    adb_regs_type r_d;
    logic [2:0] dec_area;
    logic [3:0] dec_wait;
    logic [1:0] dec_width;
    logic [1:0] dec_mem;
    logic dec_card;
    logic [1:0] eff_size;

    // =========================================================
    // Decode of the incoming request
    always_comb
    begin
        dec_area = req_addr_i[AREA_HI:AREA_LO]; // see RULE1 see RULE2
        dec_wait = 4'h0;
        dec_width = WIDTH_LONG;
        dec_mem = MEM_ORDINARY;
        dec_card = 1'b0;
        eff_size = req_fill_i ? WIDTH_LONG : req_size_i; // see RULE20
        case (dec_area)
            AREA0_CODE:
            begin
                dec_wait = (area0_wait_field_i == 3'h7) ? WAIT_MAX_LONG : {1'b0, area0_wait_field_i}; // see RULE5
                dec_width = area0_width_pins_i; // see RULE8
            end
            AREA2_CODE:
            begin
                dec_wait = {2'b00, area2_wait_field_i}; // see RULE6
                dec_mem = area2_mem_type_i;
                dec_width = (area2_mem_type_i == MEM_DRAM) ? WIDTH_WORD :
                            (area2_mem_type_i == MEM_SDRAM) ? WIDTH_LONG : area2_width_field_i; // see RULE9
            end
            AREA3_CODE:
            begin
                dec_wait = {2'b00, area3_wait_field_i}; // see RULE6
                dec_mem = area3_mem_type_i;
                dec_width = (area3_mem_type_i == MEM_DRAM) ? (dram_width_select_i ? WIDTH_LONG : WIDTH_WORD) :
                            (area3_mem_type_i == MEM_SDRAM) ? WIDTH_LONG : area3_width_field_i; // see RULE10
            end
            AREA4_CODE:
            begin
                dec_wait = (area4_wait_field_i == 3'h7) ? WAIT_MAX_LONG : {1'b0, area4_wait_field_i};
                dec_width = area4_width_field_i; // see RULE9
            end
            AREA5_CODE:
            begin
                dec_wait = (area5_wait_field_i == 3'h7) ? WAIT_MAX_LONG : {1'b0, area5_wait_field_i};
                dec_card = area5_card_mode_i;
                dec_width = (area5_card_mode_i && area5_width_field_i == WIDTH_LONG) ? WIDTH_WORD : area5_width_field_i;
            end
            AREA6_CODE:
            begin
                dec_wait = (area6_wait_field_i == 3'h7) ? WAIT_MAX_LONG : {1'b0, area6_wait_field_i};
                dec_card = area6_card_mode_i;
                dec_width = (area6_card_mode_i && area6_width_field_i == WIDTH_LONG) ? WIDTH_WORD : area6_width_field_i;
            end
            default:
            begin
                dec_wait = 4'h0;
            end
        endcase
    end

    // =========================================================
    // Bus sequencer
    always_comb
    begin
        r_d = r_q;
        r_d.bs_n = 1'b1;
        r_d.ack = 1'b0;
        // Strap is caught on the first clock after reset release.
        if (!r_q.strap_seen)
        begin
            r_d.strap_seen = 1'b1;
            r_d.little_endian = endian_strap_pin_i; // see RULE23
        end
        case (r_q.st)
            ST_IDLE:
            begin
                if (req_i)
                begin
                    r_d.st = ST_FIRST;
                    r_d.area = dec_area;
                    r_d.write = req_write_i;
                    r_d.fill = req_fill_i;
                    r_d.beat = 3'h0;
                    r_d.wait_cfg = dec_wait;
                    r_d.waits_left = dec_wait;
                    r_d.width = dec_width;
                    r_d.addr = req_fill_i ? {req_addr_i[ADDR_W-1:4], 4'h0} : req_addr_i;
                    // Byte strobes come only from bytes being written, none on reads.
                    r_d.bytes = (eff_size == WIDTH_LONG) ? 4'hf : req_bytes_i; // see RULE17 see RULE18
                    r_d.bs_n = 1'b0; // see RULE15
                    if (dec_area != AREA1_CODE)
                    begin
                        r_d.cs_n[dec_area] = 1'b0; // see RULE4
                        r_d.rd_n = req_write_i;
                        r_d.rdwr = ~req_write_i;
                        r_d.ras_n = ~((dec_area == AREA2_CODE || dec_area == AREA3_CODE) && dec_mem != MEM_ORDINARY);
                        r_d.dqm = (dec_mem == MEM_SDRAM) ? ~r_d.bytes : 4'h0; // see RULE11
                        r_d.io_n = ~(dec_area == AREA6_CODE && dec_card); // see RULE12
                        r_d.setup = (dec_area == AREA5_CODE) ? {2'b00, area5_card_setup_i} :
                                    {2'b00, area6_card_setup_i}; // see RULE13
                        r_d.hold = (dec_area == AREA5_CODE) ? {2'b00, area5_card_hold_i} :
                                   {2'b00, area6_card_hold_i};
                    end
                    else
                    begin
                        r_d.rd_n = 1'b1; // see RULE24 see RULE3
                    end
                end
            end
            ST_FIRST:
            begin
                if (r_q.area != AREA1_CODE && r_q.write)
                    r_d.we_n = ~r_q.bytes;
                if (r_q.area != AREA1_CODE && !r_q.ras_n)
                    r_d.cas_n = 1'b0;
                r_d.st = (r_q.waits_left != 4'h0) ? ST_WAIT : ST_FINAL; // see RULE14 see RULE21
            end
            ST_WAIT:
            begin
                // The wait pin is launched on this bus clock, so it is read directly: a synchroniser would
                // delay it two cycles and let a wait raised in the first state stretch the access.
                if (r_q.waits_left > 4'h1)
                    r_d.waits_left = r_q.waits_left - 4'h1;
                else if (ext_wait_n_i) // see RULE22
                    r_d.st = ST_FINAL;
            end
            ST_FINAL:
            begin
                // Chip select is released at the clock edge that ends this state, except between line beats.
                r_d.cs_n = 7'h7f; // see RULE16
                r_d.rd_n = 1'b1;
                r_d.we_n = 4'hf;
                r_d.ras_n = 1'b1;
                r_d.cas_n = 1'b1;
                r_d.io_n = 1'b1;
                r_d.dqm = 4'h0;
                if (r_q.fill && r_q.beat != LINE_BEATS_M1 && r_q.area != AREA1_CODE)
                begin
                    // Next beat of a 16-byte line starts at once, bus kept.
                    r_d.beat = r_q.beat + 3'h1; // see RULE19
                    r_d.addr = r_q.addr + 32'h4;
                    // A beat lasts two clocks plus its waits, so waits are capped to keep the pitch at or below ten.
                    r_d.waits_left = (r_q.wait_cfg > WAIT_MAX_LONG - BURST_PITCH_MIN) ?
                                     WAIT_MAX_LONG - BURST_PITCH_MIN : r_q.wait_cfg; // see RULE7
                    r_d.st = ST_FIRST;
                    r_d.bs_n = 1'b0;
                    r_d.cs_n[r_q.area] = 1'b0;
                    r_d.rd_n = r_q.write;
                end
                else
                begin
                    r_d.st = ST_IDLE;
                    r_d.ack = 1'b1;
                end
            end
            default:
            begin
                r_d.st = ST_IDLE;
            end
        endcase
        r_d.busy = (r_d.st != ST_IDLE);
        r_d.in1 = (r_d.area == AREA1_CODE) && (r_d.st != ST_IDLE);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.bs_n <= 1'b1;
            r_q.cs_n <= 7'h7f;
            r_q.rd_n <= 1'b1;
            r_q.we_n <= 4'hf;
            r_q.ras_n <= 1'b1;
            r_q.cas_n <= 1'b1;
            r_q.io_n <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    // =========================================================
    // Outputs
    assign ack_o = r_q.ack;
    assign busy_o = r_q.busy;
    assign bus_cycle_start_n_o = r_q.bs_n;
    assign area_chip_select_n_o = r_q.cs_n;
    assign read_strobe_n_o = r_q.rd_n;
    assign byte_write_strobes_n_o = r_q.we_n;
    assign row_strobe_n_o = r_q.ras_n;
    assign column_strobe_n_o = r_q.cas_n;
    assign rd_wr_o = r_q.rdwr;
    assign byte_mask_o = r_q.dqm;
    assign card_io_n_o = r_q.io_n;
    assign ext_addr_o = r_q.addr;
    assign cycle_width_o = r_q.width;
    assign card_setup_o = r_q.setup;
    assign card_hold_o = r_q.hold;
    assign area1_internal_o = r_q.in1;
    assign little_endian_o = r_q.little_endian;

    // =========================================================
    // Checks
    AST_BS_ONE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !bus_cycle_start_n_o |=> bus_cycle_start_n_o) else $error("start pulse too long"); // see RULE15
    AST_TWO_CYCLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (r_q.st == ST_FIRST && r_q.waits_left == 4'h0) |=> r_q.st == ST_FINAL) else $error("no-wait not two"); // see RULE14
    AST_AREA1: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        area1_internal_o |-> (area_chip_select_n_o == 7'h7f && read_strobe_n_o)) else $error("area1 strobe"); // see RULE24
    AST_CS_DROP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (r_q.st == ST_FINAL && !r_q.fill) |=> area_chip_select_n_o == 7'h7f) else $error("cs stuck"); // see RULE16
    AST_WAIT_IGN: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (r_q.st == ST_WAIT && r_q.waits_left > 4'h1) |=> r_q.st == ST_WAIT) else $error("early final"); // see RULE22
    AST_WE_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (!r_q.write) |-> byte_write_strobes_n_o == 4'hf) else $error("strobe on read"); // see RULE18
    AST_DECODE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (r_q.st == ST_IDLE && req_i && dec_area != AREA1_CODE) |=> !area_chip_select_n_o[$past(dec_area)])
        else $error("wrong select"); // see RULE1
    AST_ENDIAN: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        r_q.strap_seen |=> $stable(little_endian_o)) else $error("endian changed"); // see RULE23
endmodule // adb_area_bus

//--- adb_mem_model.sv
// Behavioural external static memory that can stretch accesses through the wait pin.
`timescale 1ns/1ps
module adb_mem_model
(
    // Clock
    input wire logic clk_sys_i,
    // Bus side
    input wire logic [6:0] area_chip_select_n_i,
    input wire logic [3:0] stall_i,
    output logic ext_wait_n_o
);
    int left = 0;
    logic sel_q = 1'b0;
    // =========================================================
    // Wait generation
    // The pin is driven high whenever the memory is not stalling.
    always @(posedge clk_sys_i)
    begin
        sel_q <= ~&area_chip_select_n_i;
        if (~&area_chip_select_n_i && !sel_q)
            left <= stall_i;
        else if (left > 0)
            left <= left - 1;
    end
    assign ext_wait_n_o = !(left > 0);
endmodule // adb_mem_model

//--- area_decode_static_bus_tb_top.sv
// Self-checking testbench for the area decoder and static bus engine.
`timescale 1ns/1ps
module area_decode_static_bus_tb_top;
    import adb_pkg::*;
    logic clk = 1'b0, srst = 1'b1, strap = 1'b0, req = 1'b0, wr = 1'b0, fill = 1'b0, wait_n;
    logic [1:0] wp = 2'h3, w2 = 2'h0, w3 = 2'h0, z2 = 2'h3, z3 = 2'h3, z4 = 2'h3, z5 = 2'h3, z6 = 2'h3;
    logic [1:0] sz = 2'h3, s5 = 2'h0, h5 = 2'h0, s6 = 2'h0, h6 = 2'h0;
    logic [2:0] w0 = 3'h0, w4 = 3'h0, w5 = 3'h0, w6 = 3'h0;
    logic [31:0] addr = 32'h0;
    logic [3:0] bytes = 4'hf, stall = 4'h0, we_n, lanes[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    logic ack, bs_n, rd_n, in1, le, busy, ras_n, cas_n, rdwr, io_n;
    logic [3:0] bm, cset, chold;
    logic [31:0] ea;
    logic [6:0] cs_n;
    logic [1:0] cw;
    int n_fail = 0, compares = 0, cyc = 0, areas[$] = '{0, 1, 2, 3, 4, 5, 6};

    adb_area_bus dut_u (.clk_sys_i(clk), .srst_i(srst), .endian_strap_pin_i(strap), .area0_width_pins_i(wp),
        .area0_wait_field_i(w0), .area2_wait_field_i(w2), .area3_wait_field_i(w3), .area4_wait_field_i(w4),
        .area5_wait_field_i(w5), .area6_wait_field_i(w6), .area2_width_field_i(z2), .area3_width_field_i(z3),
        .area4_width_field_i(z4), .area5_width_field_i(z5), .area6_width_field_i(z6), .area2_mem_type_i(2'h0),
        .area3_mem_type_i(2'h0), .dram_width_select_i(1'b1), .area5_card_mode_i(1'b0), .area6_card_mode_i(1'b0),
        .area5_card_setup_i(s5), .area5_card_hold_i(h5), .area6_card_setup_i(s6), .area6_card_hold_i(h6),
        .req_i(req), .req_write_i(wr), .req_addr_i(addr), .req_size_i(sz), .req_fill_i(fill),
        .req_bytes_i(bytes), .ack_o(ack), .busy_o(busy), .ext_wait_n_i(wait_n), .bus_cycle_start_n_o(bs_n),
        .area_chip_select_n_o(cs_n), .read_strobe_n_o(rd_n), .byte_write_strobes_n_o(we_n),
        .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n), .rd_wr_o(rdwr), .byte_mask_o(bm), .card_io_n_o(io_n),
        .ext_addr_o(ea), .cycle_width_o(cw), .card_setup_o(cset), .card_hold_o(chold), .area1_internal_o(in1),
        .little_endian_o(le));

    adb_mem_model mem_u (.clk_sys_i(clk), .area_chip_select_n_i(cs_n), .stall_i(stall), .ext_wait_n_o(wait_n));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // =========================================================
    // Reference model
    // A three-bit field of seven stands for ten waits; two-bit fields count straight.
    function automatic int exp_wait(int a);
        int x;
        x = (a == 0) ? w0 : (a == 1) ? 0 : (a == 2) ? w2 : (a == 3) ? w3 : (a == 4) ? w4 : (a == 5) ? w5 : w6;
        return (x == 7 && a != 2 && a != 3) ? 10 : x;
    endfunction

    function automatic logic [1:0] exp_width(int a);
        return (a == 0) ? wp : (a == 2) ? z2 : (a == 3) ? z3 : (a == 4) ? z4 : (a == 5) ? z5 : z6;
    endfunction

    // A negative latency means the access must take longer than its magnitude.
    task automatic run(int a, logic w, logic f, logic [3:0] st, int lat);
        int n, nbs, li;
        logic [6:0] cs_seen;
        logic [3:0] we_seen;
        logic rd_seen, i1, mem_seen;
        n = 0;
        mem_seen = 1'b0;
        li = $urandom_range(6, 0);
        nbs = 0;
        cs_seen = 7'h0;
        we_seen = 4'h0;
        rd_seen = 1'b0;
        i1 = 1'b0;
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        fill <= f;
        stall <= st;
        bytes <= lanes[li];
        // Lane sets 0 to 3 are single bytes, 4 and 5 halves, 6 the whole longword.
        sz <= (li < 4) ? WIDTH_BYTE : (li < 6) ? WIDTH_WORD : WIDTH_LONG;
        addr <= {3'($urandom_range(7, 0)), a[2:0], 26'($urandom_range(32'h3ffffff, 0))}
            & (f ? 32'hfffffff0 : 32'hffffffff);
        @(posedge clk);
        req <= 1'b0;
        #1;
        while (ack !== 1'b1 && n < 300)
        begin
            if (bs_n === 1'b0)
            begin
                nbs++;
                chk("busy", busy, 1'b1);
                chk("addr", ea, addr + (f ? 32'(4 * (nbs - 1)) : 32'h0));
                if (a != 1)
                begin
                    chk("width", cw, exp_width(a));
                    chk("rd_wr", rdwr, !w);
                end
            end
            cs_seen |= ~cs_n;
            we_seen |= ~we_n;
            rd_seen |= ~rd_n;
            i1 |= in1;
            mem_seen |= ~ras_n | ~cas_n | (|bm) | ~io_n;
            @(posedge clk);
            #1;
            n++;
        end
        chk("ack", ack, 1'b1);
        chk("busy", busy, 1'b0);
        chk("strobes", mem_seen, 1'b0);
        if (a == 5 || a == 6)
        begin
            chk("card_setup", cset, (a == 5) ? s5 : s6);
            chk("card_hold", chold, (a == 5) ? h5 : h6);
        end
        chk("select", cs_seen, (a == 1) ? 7'h0 : 7'h1 << a);
        chk("write_lanes", we_seen, (a == 1 || !w) ? 4'h0 : f ? 4'hf : bytes);
        chk("read_strobe", rd_seen, a != 1 && !w);
        chk("internal", i1, a == 1);
        if (a != 1)
            chk("starts", nbs, f ? 4 : 1);
        if (lat > 0 && !f)
            chk("latency", n, lat);
        if (lat < 0)
            chk("stretched", n > -lat, 1'b1);
    endtask

    initial
    begin
        void'($urandom(32'hbf6f));
        strap = $urandom_range(1, 0);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("endian", le, strap);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            {w0, w4, w5, w6} <= $urandom();
            {w2, w3} <= $urandom();
            {s5, h5, s6, h6} <= 8'($urandom());
            {wp, z2, z3, z4, z5, z6} <= {$urandom_range(3, 1), $urandom_range(3, 1), $urandom_range(3, 1),
                $urandom_range(3, 1), $urandom_range(3, 1), $urandom_range(3, 1)};
            areas.shuffle();
            @(posedge clk);
            run(areas[0], $urandom_range(1, 0), 1'b0, 4'h0, 2 + exp_wait(areas[0]));
        end
        // Every wait code on both field widths, back to back.
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            w4 <= i;
            w3 <= i;
            @(posedge clk);
            run(4, 1'b1, 1'b0, 4'h0, 2 + ((i == 7) ? 10 : i));
            run(3, 1'b0, 1'b0, 4'h0, 2 + i % 4);
        end
        @(posedge clk);
        w0 <= 3'h0;
        w2 <= 2'h2;
        @(posedge clk);
        run(0, 1'b0, 1'b0, 4'h6, 2);
        run(2, 1'b0, 1'b0, 4'h6, -5);
        run(3, 1'b0, 1'b1, 4'h0, 0);
        run(5, 1'b1, 1'b1, 4'h0, 0);
        end_sim();
    end
endmodule // area_decode_static_bus_tb_top
